// *** lsst_pkg.sv ***
package lsst_pkg;
  localparam int unsigned PIXEL_COUNT = 4096;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned IRR_W = 8;
  localparam int unsigned VIDEO_W = 16;
  localparam int unsigned INTEG_W = 16;
  localparam int unsigned CNT_W = 13;
  localparam int unsigned BUF_DEPTH = 2;
  // pixel clocks, counted in the scan
  localparam logic [12:0] PIXEL_TOTAL = 13'h1000;
  localparam logic [12:0] LEAD_STROBES = 13'h0058;
  localparam logic [12:0] FIRST_VALID = 13'h0059;
  localparam logic [12:0] LAST_VALID = 13'h1058;
  localparam logic [12:0] END_STROBE = 13'h1059;
  localparam logic [15:0] EXTRA_INTEG = 16'h0030;
  localparam logic [15:0] INTEG_MAX = 16'hFFFF;
  localparam logic [15:0] VIDEO_MAX = 16'hFFFF;
  localparam logic [1:0] BUF_FULL = 2'h2;

  typedef enum logic [1:0] {
    LSST_IDLE,
    LSST_INTEG,
    LSST_SCAN
  } lsst_phase_type;

  typedef struct packed {
    logic st_s1;
    logic st_s2;
    logic st_s3;
    logic pc_s1;
    logic pc_s2;
    logic pc_s3;
    lsst_phase_type phase;
    logic [15:0] high_cnt;
    logic [15:0] integ;
    logic [12:0] strobe_cnt;
    logic [12:0] rd_addr;
    logic rd_pend;
    logic [7:0] buf0;
    logic [7:0] buf1;
    logic [1:0] buf_cnt;
    logic [15:0] video;
    logic strobe;
    logic valid;
    logic finished;
  } lsst_state_type;
endpackage

// *** lsst_mem_if.sv ***
`timescale 1ns/1ps
interface lsst_mem_if;
  logic wr_en;
  logic [11:0] wr_addr;
  logic [7:0] wr_data;
  logic rd_en;
  logic [11:0] rd_addr;
  logic [7:0] rd_data;
  logic rd_valid;
  modport ctrl (
    output wr_en, wr_addr, wr_data, rd_en, rd_addr,
    input rd_data, rd_valid
  );
  modport store (
    input wr_en, wr_addr, wr_data, rd_en, rd_addr,
    output rd_data, rd_valid
  );
endinterface

// *** lsst_pixel_mem.sv ***
`timescale 1ns/1ps
module lsst_pixel_mem (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // access port
  lsst_mem_if.store mem
);
  import lsst_pkg::*;

  logic [7:0] cells [PIXEL_COUNT];
  logic [7:0] rd_data_q;
  logic rd_valid_q;

  // scene cells carry no reset; contents are undefined until written
  always_ff @(posedge clk) begin
    if (mem.wr_en) begin
      cells[mem.wr_addr] <= mem.wr_data;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_data_q <= 8'h00;
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= mem.rd_en;
      if (mem.rd_en) begin
        rd_data_q <= cells[mem.rd_addr];
      end
    end
  end

  assign mem.rd_data = rd_data_q;
  assign mem.rd_valid = rd_valid_q;
endmodule // lsst_pixel_mem

// *** lsst_top.sv ***
`timescale 1ns/1ps
// Function
// - only start pulse and pixel clock drive timing
// - 4096 pixels shifted out on video
// - one common exposure for all pixels
// - shifting starts first clock rise after fall
// - exposure equals high time plus 48 clocks
// - strobe per pixel, sampled on its rise
// - first valid pixel at 89th strobe
module lsst_top (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // sensor pins from the controller
  input wire logic scan_start_pulse,
  input wire logic pixel_clk,
  // scene irradiance load, same clock
  input wire logic scene_wr_en,
  input wire logic [lsst_pkg::ADDR_W-1:0] scene_wr_addr,
  input wire logic [lsst_pkg::IRR_W-1:0] scene_wr_data,
  // video outputs
  output logic [lsst_pkg::VIDEO_W-1:0] video_level,
  output logic video_strobe,
  output logic video_valid,
  output logic scan_finished
);
  import lsst_pkg::*;

  lsst_state_type q;
  lsst_state_type d;
  logic st_rise;
  logic st_fall;
  logic pc_rise;
  logic pc_fall;
  logic rd_issue;
  logic push;
  logic pop;
  logic [12:0] strobe_next;

  lsst_mem_if mem ();

  lsst_pixel_mem u_mem (
    .clk(clk),
    .resetn(resetn),
    .mem(mem)
  );

  // exposure-scaled level, saturating at full scale
  function automatic logic [15:0] f_scale(input logic [7:0] irr,
                                          input logic [15:0] integ);
    logic [23:0] prod;
    prod = {16'h0000, irr} * {8'h00, integ};
    if (prod[23:16] != 8'h00) begin
      return VIDEO_MAX;
    end
    return prod[15:0];
  endfunction

  assign mem.wr_en = scene_wr_en;
  assign mem.wr_addr = scene_wr_addr;
  assign mem.wr_data = scene_wr_data;
  assign mem.rd_en = rd_issue;
  assign mem.rd_addr = q.rd_addr[11:0];

  always_comb begin
    d = q;
    // pins pass two flops before use
    d.st_s1 = scan_start_pulse;
    d.st_s2 = q.st_s1;
    d.st_s3 = q.st_s2;
    d.pc_s1 = pixel_clk;
    d.pc_s2 = q.pc_s1;
    d.pc_s3 = q.pc_s2;
    st_rise = q.st_s2 & ~q.st_s3;
    st_fall = ~q.st_s2 & q.st_s3;
    pc_rise = q.pc_s2 & ~q.pc_s3;
    pc_fall = ~q.pc_s2 & q.pc_s3;
    strobe_next = q.strobe_cnt + 13'h0001;
    // prefetch scene words; stalls while buffer full or read pending
    rd_issue = (q.phase == LSST_SCAN) && (q.rd_addr < PIXEL_TOTAL) &&
               !q.rd_pend && (q.buf_cnt != BUF_FULL);
    push = mem.rd_valid && (q.phase == LSST_SCAN);
    pop = (q.phase == LSST_SCAN) && pc_rise &&
          (strobe_next >= FIRST_VALID) && (strobe_next <= LAST_VALID) &&
          (q.buf_cnt != 2'h0);
    if (rd_issue) begin
      d.rd_addr = q.rd_addr + 13'h0001;
      d.rd_pend = 1'b1;
    end else if (mem.rd_valid) begin
      d.rd_pend = 1'b0;
    end
    // two-entry buffer between scene store and video output
    case ({push, pop})
      2'b01: begin
        d.buf0 = q.buf1;
        d.buf_cnt = q.buf_cnt - 2'h1;
      end
      2'b10: begin
        if (q.buf_cnt == 2'h0) begin
          d.buf0 = mem.rd_data;
        end else begin
          d.buf1 = mem.rd_data;
        end
        d.buf_cnt = q.buf_cnt + 2'h1;
      end
      2'b11: begin
        if (q.buf_cnt == 2'h1) begin
          d.buf0 = mem.rd_data;
        end else begin
          d.buf0 = q.buf1;
          d.buf1 = mem.rd_data;
        end
      end
      default: begin
      end
    endcase
    case (q.phase)
      LSST_IDLE: begin
      end
      LSST_INTEG: begin
        if (pc_rise && q.st_s2 && (q.high_cnt != INTEG_MAX)) begin
          d.high_cnt = q.high_cnt + 16'h0001;
        end
        if (st_fall) begin
          // latched once, shared by every pixel of the line
          if (q.high_cnt > (INTEG_MAX - EXTRA_INTEG)) begin
            d.integ = INTEG_MAX;
          end else begin
            d.integ = q.high_cnt + EXTRA_INTEG;
          end
          d.phase = LSST_SCAN;
          d.strobe_cnt = 13'h0000;
          d.rd_addr = 13'h0000;
          d.rd_pend = 1'b0;
          d.buf_cnt = 2'h0;
        end
      end
      LSST_SCAN: begin
        if (pc_rise) begin
          d.strobe_cnt = strobe_next;
          d.strobe = 1'b0;
          if (pop) begin
            d.video = f_scale(q.buf0, q.integ);
            d.valid = 1'b1;
          end else begin
            d.video = 16'h0000;
            d.valid = 1'b0;
          end
          if (strobe_next == END_STROBE) begin
            d.finished = 1'b1;
            d.phase = LSST_IDLE;
          end
        end else if (pc_fall && (q.strobe_cnt != 13'h0000) &&
                     (q.strobe_cnt <= LAST_VALID)) begin
          d.strobe = 1'b1;
        end
      end
      default: begin
        d.phase = LSST_IDLE;
      end
    endcase
    // a new start pulse aborts any line in progress
    if (st_rise) begin
      d.phase = LSST_INTEG;
      d.high_cnt = 16'h0000;
      d.strobe = 1'b0;
      d.valid = 1'b0;
      d.video = 16'h0000;
      d.finished = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign video_level = q.video;
  assign video_strobe = q.strobe;
  assign video_valid = q.valid;
  assign scan_finished = q.finished;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence seq_st_fall;
    (q.phase == LSST_INTEG) && st_fall && !st_rise;
  endsequence

  sequence seq_scan_entry;
    (q.phase == LSST_SCAN) && (q.strobe_cnt == 13'h0000);
  endsequence

  a_scan_entry:
    assert property (seq_st_fall |=> seq_scan_entry)
    else $error("scan did not start after start pulse fall");

  a_integ_time:
    assert property (seq_st_fall and (q.high_cnt < 16'h1000)
      |=> q.integ == $past(q.high_cnt) + 16'h0030)
    else $error("exposure is not high time plus 48 clocks");

  a_expo_stable:
    assert property ((q.phase == LSST_SCAN) && ($past(q.phase) == LSST_SCAN)
      |-> $stable(q.integ))
    else $error("exposure changed inside a line");

  a_first_valid:
    assert property ($rose(q.valid) |-> q.strobe_cnt == 13'h0059)
    else $error("first valid pixel not at 89th strobe");

  a_strobe_scan:
    assert property (q.strobe |-> (q.phase == LSST_SCAN) &&
      (q.strobe_cnt >= 13'h0001) && (q.strobe_cnt <= 13'h1058))
    else $error("strobe outside the scan");

  a_strobe_drop:
    assert property ((q.phase == LSST_SCAN) && pc_rise |=> !q.strobe)
    else $error("strobe not lowered at pixel clock rise");

  a_video_timing:
    assert property (!$stable(q.video) |-> $past(pc_rise) || $past(st_rise))
    else $error("video changed off a pixel clock rise");

  a_buf_bound:
    assert property (q.buf_cnt <= 2'h2 && !(push && !pop && q.buf_cnt == 2'h2))
    else $error("buffer overflow");

  a_scan_end:
    assert property ($rose(q.finished) |-> q.strobe_cnt == 13'h1059 &&
      q.phase == LSST_IDLE ##1 q.finished [*2])
    else $error("end flag not raised after last pixel");
endmodule // lsst_top

// *** lsst_ctrl_model.sv ***
`timescale 1ns/1ps
module lsst_ctrl_model (
  // pacing clock
  input wire logic clk,
  // sensor pins
  output logic scan_start_pulse,
  output logic pixel_clk,
  // sensor outputs
  input wire logic [lsst_pkg::VIDEO_W-1:0] video_level,
  input wire logic video_strobe,
  input wire logic video_valid
);
  import lsst_pkg::*;
  // 26 clk period, about 9.6 MHz
  localparam int HALF = 13;
  logic [VIDEO_W-1:0] lvl [1:4200];
  logic vld [1:4200];
  int n = 0;

  initial begin
    scan_start_pulse = 1'b0;
    pixel_clk = 1'b0;
  end

  task automatic pulse();
    pixel_clk = 1'b1;
    repeat (HALF) @(negedge clk);
    pixel_clk = 1'b0;
    repeat (HALF) @(negedge clk);
  endtask

  // pixel clock stands still outside a line
  task automatic line(input int high, input int low);
    @(negedge clk);
    n = 0;
    scan_start_pulse = 1'b1;
    repeat (HALF) @(negedge clk);
    repeat (high) pulse();
    scan_start_pulse = 1'b0;
    repeat (HALF) @(negedge clk);
    repeat (low) pulse();
  endtask

  // video is taken on the strobe, not on the pixel clock
  always @(posedge video_strobe) begin
    if (n < 4200) begin
      n++;
      lvl[n] = video_level;
      vld[n] = video_valid;
    end
  end
endmodule // lsst_ctrl_model

// *** tb_linear_sensor_scan_timing.sv ***
`timescale 1ns/1ps
`define LSST_CHK(got, exp) begin \
  samples_checked++; \
  if ((got) !== (exp)) begin \
    bad_count++; \
    $display("Error t=%0t got=%h exp=%h", $time, got, exp); \
  end \
end

module tb_linear_sensor_scan_timing;
  import lsst_pkg::*;
  logic clk = 1'b0;
  logic resetn;
  logic scan_start_pulse;
  logic pixel_clk;
  logic scene_wr_en;
  logic [ADDR_W-1:0] scene_wr_addr;
  logic [IRR_W-1:0] scene_wr_data;
  logic [VIDEO_W-1:0] video_level;
  logic video_strobe;
  logic video_valid;
  logic scan_finished;
  int bad_count = 0;
  int samples_checked = 0;

  lsst_top uut (
    .clk(clk),
    .resetn(resetn),
    .scan_start_pulse(scan_start_pulse),
    .pixel_clk(pixel_clk),
    .scene_wr_en(scene_wr_en),
    .scene_wr_addr(scene_wr_addr),
    .scene_wr_data(scene_wr_data),
    .video_level(video_level),
    .video_strobe(video_strobe),
    .video_valid(video_valid),
    .scan_finished(scan_finished)
  );

  lsst_ctrl_model ctrl (
    .clk(clk),
    .scan_start_pulse(scan_start_pulse),
    .pixel_clk(pixel_clk),
    .video_level(video_level),
    .video_strobe(video_strobe),
    .video_valid(video_valid)
  );

  always #2 clk = ~clk;

  function automatic logic [7:0] irr_of(input int p);
    return 8'(p * 37 + 11);
  endfunction

  function automatic logic [15:0] exp_lvl(input int p, input int integ);
    int v;
    v = irr_of(p) * integ;
    return (v > 65535) ? 16'hFFFF : 16'(v);
  endfunction

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic t_reset();
    `LSST_CHK(video_level, 16'h0000)
    `LSST_CHK(video_strobe, 1'b0)
    `LSST_CHK(video_valid, 1'b0)
    `LSST_CHK(scan_finished, 1'b0)
    $display("reset test done");
  endtask

  task automatic load_scene();
    for (int p = 0; p < 4096; p++) begin
      @(negedge clk);
      scene_wr_en = 1'b1;
      scene_wr_addr = 12'(p);
      scene_wr_data = irr_of(p);
    end
    @(negedge clk);
    scene_wr_en = 1'b0;
    $display("scene load done");
  endtask

  // whole line, shortest high time, exposure 6 + 48 clocks
  task automatic t_full_line();
    ctrl.line(6, 4185);
    `LSST_CHK(ctrl.n, 4184)
    for (int k = 1; k <= 4184; k++) begin
      `LSST_CHK(ctrl.vld[k], (k >= 89) ? 1'b1 : 1'b0)
      `LSST_CHK(ctrl.lvl[k], (k >= 89) ? exp_lvl(k - 89, 54) : 16'h0000)
    end
    `LSST_CHK(scan_finished, 1'b1)
    `LSST_CHK(video_valid, 1'b0)
    `LSST_CHK(video_level, 16'h0000)
    $display("full line test done");
  endtask

  // shortest period, first line aborted by the next start
  task automatic t_short_lines();
    ctrl.line(20, 92);
    `LSST_CHK(scan_finished, 1'b0)
    `LSST_CHK(ctrl.n, 92)
    `LSST_CHK(ctrl.vld[88], 1'b0)
    `LSST_CHK(ctrl.lvl[89], exp_lvl(0, 68))
    `LSST_CHK(ctrl.lvl[92], exp_lvl(3, 68))
    ctrl.line(6, 92);
    `LSST_CHK(ctrl.n, 92)
    `LSST_CHK(ctrl.lvl[89], exp_lvl(0, 54))
    `LSST_CHK(video_valid, 1'b1)
    $display("short line test done");
  endtask

  initial begin
    repeat (140000) @(posedge clk);
    bad_count++;
    $display("watchdog expired");
    summarize();
  end

  initial begin
    resetn = 1'b0;
    scene_wr_en = 1'b0;
    scene_wr_addr = 12'h000;
    scene_wr_data = 8'h00;
    repeat (5) @(negedge clk);
    resetn = 1'b1;
    t_reset();
    load_scene();
    t_full_line();
    t_short_lines();
    summarize();
  end
endmodule // tb_linear_sensor_scan_timing
